//--- logic/pad_mux_pkg.sv
// pad multiplexer constants: pad count, register map, pad control layout, reset pad setup
// assumes a single 10 MHz system clock and an APB master with 12-bit byte addresses
package pad_mux_pkg;
  localparam int N_PADS = 149;
  localparam int N_PORTS = 10;
  localparam int PORT_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register regions, selected by paddr[11:10]; word index in paddr[9:2]
  localparam logic [1:0] REGION_PAD_CFG = 2'h0;
  localparam logic [1:0] REGION_GPIO_OUT = 2'h1;
  localparam logic [1:0] REGION_GPIO_IN = 2'h2;
  localparam logic [1:0] REGION_SRC_SEL = 2'h3;
  localparam int REGION_HI = 11;
  localparam int REGION_LO = 10;
  localparam int WORD_HI = 9;
  localparam int WORD_LO = 2;

  // pad_config_reg field positions
  localparam int PCR_NMI_BIT = 15;
  localparam int PCR_PA_LSB = 10;
  localparam int PCR_OBE_BIT = 9;
  localparam int PCR_IBE_BIT = 8;
  localparam int PCR_SLEW_BIT = 2;
  localparam int PCR_PULL_EN_BIT = 1;
  localparam int PCR_PULL_UP_BIT = 0;

  // alt_func_select codes
  localparam logic [1:0] AF_GPIO = 2'h0;
  localparam logic [1:0] AF_ONE = 2'h1;
  localparam logic [1:0] AF_TWO = 2'h2;

  // pads that carry the test port after reset
  localparam int TDI_PAD = 32;
  localparam int TDO_PAD = 33;
  localparam int TCK_PAD = 121;
  localparam int TMS_PAD = 122;

  // peripheral inputs picked from several candidate pads
  localparam int N_SRC = 4;
  localparam int N_CAND = 4;
  localparam int SRC_PAD [N_SRC][N_CAND] = '{'{73, 89, 95, 97}, '{75, 91, 93, 105},
                                             '{112, 139, 142, 145}, '{101, 106, 129, 131}};

  // wakeup-capable pads, and which of them may end standby
  localparam int N_WAKE = 11;
  localparam int WAKE_PAD [N_WAKE] = '{73, 75, 89, 91, 93, 99, 101, 103, 105, 129, 131};
  localparam logic [N_WAKE-1:0] WAKE_STANDBY_OK = 11'h7FC;

  // pad whose input reaches the boot-assist code
  localparam int BOOT_PAD = 91;

  typedef struct packed {
    logic nmi_en;
    logic [1:0] alt_func_select;
    logic output_buffer_enable;
    logic input_buffer_enable;
    logic slew_fast;
    logic pull_en;
    logic pull_up;
  } pad_cfg_t;

  function automatic pad_cfg_t pad_reset_cfg(input int idx);
    pad_cfg_t c;
    c = '0;
    if (idx == TCK_PAD || idx == TMS_PAD || idx == TDI_PAD) begin
      c.alt_func_select = AF_TWO;
      c.input_buffer_enable = 1'b1;
      c.pull_en = 1'b1;
      c.pull_up = 1'b1;
    end
    if (idx == TDO_PAD) begin
      c.alt_func_select = AF_TWO;
      c.output_buffer_enable = 1'b1;
    end
    return c;
  endfunction : pad_reset_cfg
endpackage : pad_mux_pkg

//--- logic/pad_alternate_function_mux.sv
// pad alternate function multiplexer with APB pad control registers
// assumes peripherals run on pclk; pad inputs are asynchronous and are synchronised here
//
// Contract
// - select code 00 gives function 0, 01 function 1, 10 and 11 function 2.
// - input functions of a pad need its input buffer enable set, whatever the select.
// - each pad input fans out to all users; shared inputs pick a pad by select field.
// - reset pad setup holds during reset and afterwards until software changes it.
// - after reset every pad is a tristate general-purpose pin except four test pads.
// - after reset test clock and mode pads are inputs with weak pull-ups.
// - after reset two more pads carry test data in and test data out.
// - with interrupt input selected on a pad, its function select is ignored.
// - test data out pad resets in function 2 with output enable preset, unused there.
// - switching test data out pad to select 0 makes it drive at once.
// - test data out pad resets to the slow slew setting, slew_fast clear.
// - every wakeup-capable pad also serves as an external interrupt source.
// - boot-only pad functions are given only while boot-assist code runs.
// - some wakeup pads cannot end standby but still wake from other modes.
module pad_alternate_function_mux
  import pad_mux_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pad_mux_pkg::ADDR_W-1:0] paddr,
  input wire logic [pad_mux_pkg::DATA_W-1:0] pwdata,
  output logic [pad_mux_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // package pads
  input wire logic [pad_mux_pkg::N_PADS-1:0] pad_in,
  output logic [pad_mux_pkg::N_PADS-1:0] pad_out,
  output logic [pad_mux_pkg::N_PADS-1:0] pad_oe,
  output logic [pad_mux_pkg::N_PADS-1:0] pad_pull_en,
  output logic [pad_mux_pkg::N_PADS-1:0] pad_pull_up,
  output logic [pad_mux_pkg::N_PADS-1:0] pad_slew_fast,
  // peripheral side
  input wire logic [pad_mux_pkg::N_PADS-1:0] af1_out,
  input wire logic [pad_mux_pkg::N_PADS-1:0] af1_oe,
  input wire logic [pad_mux_pkg::N_PADS-1:0] af2_out,
  input wire logic [pad_mux_pkg::N_PADS-1:0] af2_oe,
  output logic [pad_mux_pkg::N_PADS-1:0] periph_in,
  output logic [pad_mux_pkg::N_SRC-1:0] src_in,
  output logic nmi_request,
  output logic [pad_mux_pkg::N_WAKE-1:0] wakeup_req,
  output logic [pad_mux_pkg::N_WAKE-1:0] ext_irq,
  output logic boot_rx,
  // system mode
  input wire logic standby_mode,
  input wire logic boot_active
);
  import pad_mux_pkg::*;

  typedef struct packed {
    pad_cfg_t [N_PADS-1:0] cfg;
    logic [N_PADS-1:0] gpio_do;
    logic [N_PADS-1:0] sync1;
    logic [N_PADS-1:0] sync2;
    logic [N_PADS-1:0] pad_do;
    logic [N_PADS-1:0] pad_oe;
    logic [N_PADS-1:0] periph_in;
    logic [N_SRC-1:0][1:0] src_sel;
    logic [N_SRC-1:0] src_in;
    logic nmi;
    logic [N_WAKE-1:0] wake;
    logic [N_WAKE-1:0] eirq;
    logic boot_rx;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  function automatic state_t init_state();
    state_t s;
    s = '0;
    for (int i = 0; i < N_PADS; i++) begin
      s.cfg[i] = pad_reset_cfg(i);
    end
    return s;
  endfunction : init_state

  localparam state_t ST_RST = init_state();

  state_t st_reg;
  state_t st_next;

  // code 11 falls through to function 2
  function automatic logic af_pick(input logic [1:0] sel, input logic f0, input logic f1, input logic f2);
    case (sel)
      AF_GPIO: af_pick = f0;
      AF_ONE: af_pick = f1;
      default: af_pick = f2;
    endcase
  endfunction : af_pick

  function automatic logic [DATA_W-1:0] cfg_to_word(input pad_cfg_t c);
    logic [DATA_W-1:0] w;
    w = '0;
    w[PCR_NMI_BIT] = c.nmi_en;
    w[PCR_PA_LSB +: 2] = c.alt_func_select;
    w[PCR_OBE_BIT] = c.output_buffer_enable;
    w[PCR_IBE_BIT] = c.input_buffer_enable;
    w[PCR_SLEW_BIT] = c.slew_fast;
    w[PCR_PULL_EN_BIT] = c.pull_en;
    w[PCR_PULL_UP_BIT] = c.pull_up;
    return w;
  endfunction : cfg_to_word

  function automatic pad_cfg_t word_to_cfg(input logic [DATA_W-1:0] w);
    pad_cfg_t c;
    c.nmi_en = w[PCR_NMI_BIT];
    c.alt_func_select = w[PCR_PA_LSB +: 2];
    c.output_buffer_enable = w[PCR_OBE_BIT];
    c.input_buffer_enable = w[PCR_IBE_BIT];
    c.slew_fast = w[PCR_SLEW_BIT];
    c.pull_en = w[PCR_PULL_EN_BIT];
    c.pull_up = w[PCR_PULL_UP_BIT];
    return c;
  endfunction : word_to_cfg

  // bits past the last pad read as zero
  function automatic logic [DATA_W-1:0] port_word(input logic [N_PADS-1:0] v, input int p);
    logic [DATA_W-1:0] w;
    w = '0;
    for (int b = 0; b < PORT_W; b++) begin
      if (p * PORT_W + b < N_PADS) begin
        w[b] = v[p * PORT_W + b];
      end
    end
    return w;
  endfunction : port_word

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    int word;
    word = int'(a[WORD_HI:WORD_LO]);
    case (a[REGION_HI:REGION_LO])
      REGION_PAD_CFG: addr_ok = word < N_PADS;
      REGION_GPIO_OUT, REGION_GPIO_IN: addr_ok = word < N_PORTS;
      REGION_SRC_SEL: addr_ok = word == 0;
      default: addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  always_comb begin
    int word;
    logic [N_PADS-1:0] nmi_hit;
    logic lvl;
    word = int'(paddr[WORD_HI:WORD_LO]);
    nmi_hit = '0;
    lvl = 1'b0;
    st_next = st_reg;
    // first stage feeds only the second
    st_next.sync1 = pad_in;
    st_next.sync2 = st_reg.sync1;
    for (int i = 0; i < N_PADS; i++) begin
      st_next.periph_in[i] = st_reg.sync2[i] & st_reg.cfg[i].input_buffer_enable;
      nmi_hit[i] = st_reg.periph_in[i] & st_reg.cfg[i].nmi_en;
      st_next.pad_do[i] = af_pick(st_reg.cfg[i].alt_func_select, st_reg.gpio_do[i],
                                  af1_out[i], af2_out[i]);
      // output enable only matters in function 0, so the preset on the test data out pad is idle there
      st_next.pad_oe[i] = af_pick(st_reg.cfg[i].alt_func_select, st_reg.cfg[i].output_buffer_enable,
                                  af1_oe[i], af2_oe[i]) & ~st_reg.cfg[i].nmi_en;
    end
    st_next.nmi = |nmi_hit;
    for (int s = 0; s < N_SRC; s++) begin
      st_next.src_in[s] = st_reg.periph_in[SRC_PAD[s][st_reg.src_sel[s]]];
    end
    for (int w = 0; w < N_WAKE; w++) begin
      lvl = st_reg.periph_in[WAKE_PAD[w]];
      st_next.eirq[w] = lvl;
      st_next.wake[w] = lvl & (~standby_mode | WAKE_STANDBY_OK[w]);
    end
    st_next.boot_rx = st_reg.periph_in[BOOT_PAD] & boot_active;
    // no wait state: answer registered in the setup cycle, ready in the first access cycle
    st_next.pready = psel & ~penable;
    st_next.pslverr = 1'b0;
    if (psel && !penable) begin
      st_next.pslverr = ~addr_ok(paddr);
      st_next.prdata = '0;
      if (addr_ok(paddr)) begin
        case (paddr[REGION_HI:REGION_LO])
          REGION_PAD_CFG: st_next.prdata = cfg_to_word(st_reg.cfg[word]);
          REGION_GPIO_OUT: st_next.prdata = port_word(st_reg.gpio_do, word);
          REGION_GPIO_IN: st_next.prdata = port_word(st_reg.sync2, word);
          default: st_next.prdata = DATA_W'(st_reg.src_sel);
        endcase
      end
    end else if (psel && penable && st_reg.pready) begin
      st_next.pslverr = st_reg.pslverr;
    end
    // writes take effect at the completing edge; gpio input words are read-only
    if (psel && penable && st_reg.pready && pwrite && !st_reg.pslverr) begin
      case (paddr[REGION_HI:REGION_LO])
        REGION_PAD_CFG: st_next.cfg[word] = word_to_cfg(pwdata);
        REGION_GPIO_OUT: begin
          for (int b = 0; b < PORT_W; b++) begin
            if (word * PORT_W + b < N_PADS) begin
              st_next.gpio_do[word * PORT_W + b] = pwdata[b];
            end
          end
        end
        REGION_SRC_SEL: st_next.src_sel = pwdata[2*N_SRC-1:0];
        default: st_next.gpio_do = st_reg.gpio_do;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    for (int i = 0; i < N_PADS; i++) begin
      pad_pull_en[i] = st_reg.cfg[i].pull_en;
      pad_pull_up[i] = st_reg.cfg[i].pull_up;
      pad_slew_fast[i] = st_reg.cfg[i].slew_fast;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign pad_out = st_reg.pad_do;
  assign pad_oe = st_reg.pad_oe;
  assign periph_in = st_reg.periph_in;
  assign src_in = st_reg.src_in;
  assign nmi_request = st_reg.nmi;
  assign wakeup_req = st_reg.wake;
  assign ext_irq = st_reg.eirq;
  assign boot_rx = st_reg.boot_rx;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  localparam int PROBE = 17;
  localparam logic [ADDR_W-1:0] PROBE_ADDR = 12'h044;

  sequence s_setup_wr;
    psel && !penable && pwrite && paddr == PROBE_ADDR;
  endsequence
  sequence s_access_done;
    psel && penable && pready && $stable(pwdata);
  endsequence

  property p_af_gpio;
    st_reg.cfg[TDO_PAD].alt_func_select == AF_GPIO |=> pad_out[TDO_PAD] == $past(st_reg.gpio_do[TDO_PAD]);
  endproperty
  a_af_gpio: assert property (p_af_gpio) else $error("select 0 does not route gpio data");

  property p_af_code3;
    st_reg.cfg[PROBE].alt_func_select == 2'h3 |=> pad_out[PROBE] == $past(af2_out[PROBE]);
  endproperty
  a_af_code3: assert property (p_af_code3) else $error("select 3 does not route function 2");

  property p_ibe_gate;
    !st_reg.cfg[PROBE].input_buffer_enable |=> !periph_in[PROBE];
  endproperty
  a_ibe_gate: assert property (p_ibe_gate) else $error("input passed with buffer disabled");

  property p_fanout;
    st_reg.cfg[PROBE].input_buffer_enable [*3] |-> periph_in[PROBE] == $past(pad_in[PROBE], 3);
  endproperty
  a_fanout: assert property (p_fanout) else $error("pad input not delivered after sync");

  property p_src_sel;
    st_reg.src_sel[0] == 2'h0 |=> src_in[0] == $past(periph_in[SRC_PAD[0][0]]);
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("source select picked wrong pad");

  property p_reset_pads;
    disable iff (1'b0)
    !presetn |-> pad_oe == '0 && pad_pull_up[TCK_PAD] && pad_pull_en[TMS_PAD] && !pad_pull_en[PROBE];
  endproperty
  a_reset_pads: assert property (p_reset_pads) else $error("reset pad setup wrong");

  property p_reset_tdo;
    disable iff (1'b0)
    !presetn |-> st_reg.cfg[TDO_PAD].alt_func_select == AF_TWO && st_reg.cfg[TDO_PAD].output_buffer_enable
                 && !pad_slew_fast[TDO_PAD];
  endproperty
  a_reset_tdo: assert property (p_reset_tdo) else $error("test data out pad reset setup wrong");

  property p_tdo_gpio;
    st_reg.cfg[TDO_PAD].alt_func_select == AF_GPIO && st_reg.cfg[TDO_PAD].output_buffer_enable
      && !st_reg.cfg[TDO_PAD].nmi_en |=> pad_oe[TDO_PAD];
  endproperty
  a_tdo_gpio: assert property (p_tdo_gpio) else $error("test data out pad not driving in gpio");

  property p_nmi_prio;
    st_reg.cfg[PROBE].nmi_en |=> !pad_oe[PROBE];
  endproperty
  a_nmi_prio: assert property (p_nmi_prio) else $error("pad drives with interrupt input selected");

  property p_standby_block;
    standby_mode |=> !wakeup_req[0] && !wakeup_req[1];
  endproperty
  a_standby_block: assert property (p_standby_block) else $error("blocked pad woke from standby");

  property p_wake_irq;
    wakeup_req != '0 |-> (ext_irq & wakeup_req) == wakeup_req;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("wakeup without external interrupt");

  property p_boot_only;
    !boot_active |=> !boot_rx;
  endproperty
  a_boot_only: assert property (p_boot_only) else $error("boot function outside boot");

  property p_reg_index;
    s_setup_wr ##1 s_access_done |=> st_reg.cfg[PROBE] == word_to_cfg($past(pwdata));
  endproperty
  a_reg_index: assert property (p_reg_index) else $error("pad 17 register not at word 17");

  property p_af_one;
    st_reg.cfg[PROBE].alt_func_select == AF_ONE |=> pad_out[PROBE] == $past(af1_out[PROBE]);
  endproperty
  a_af_one: assert property (p_af_one) else $error("select 1 does not route function 1");

  property p_tdo_af2;
    st_reg.cfg[TDO_PAD].alt_func_select == AF_TWO && !st_reg.cfg[TDO_PAD].nmi_en |=> pad_oe[TDO_PAD] == $past(af2_oe[TDO_PAD]);
  endproperty
  a_tdo_af2: assert property (p_tdo_af2) else $error("output enable bit acts in function 2");

  property p_nmi_req;
    st_reg.cfg[PROBE].nmi_en && periph_in[PROBE] |=> nmi_request;
  endproperty
  a_nmi_req: assert property (p_nmi_req) else $error("interrupt input not raised");

  property p_irq_follow;
    1'b1 |=> ext_irq[0] == $past(periph_in[WAKE_PAD[0]]);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("wakeup pad not an interrupt source");

  property p_wake_free;
    !standby_mode |=> wakeup_req == ext_irq;
  endproperty
  a_wake_free: assert property (p_wake_free) else $error("wakeup blocked outside standby");

  property p_boot_pass;
    boot_active |=> boot_rx == $past(periph_in[BOOT_PAD]);
  endproperty
  a_boot_pass: assert property (p_boot_pass) else $error("boot input not passed while booting");
endmodule : pad_alternate_function_mux

//--- testbench/pad_far_side.sv
// far side model: package pads and the peripherals behind functions 1 and 2
// assumes the bench hands it fresh levels and the mux drives pad_out and pad_oe
module pad_far_side
  import pad_mux_pkg::*;
(
  // clock
  input wire logic pclk,
  // levels chosen by the bench: outside pad source, then af1 data/oe, af2 data/oe
  input wire logic [4:0][N_PADS-1:0] stim,
  // pad side of the mux
  input wire logic [N_PADS-1:0] pad_out,
  input wire logic [N_PADS-1:0] pad_oe,
  output logic [N_PADS-1:0] pad_in,
  // peripheral outputs
  output logic [N_PADS-1:0] af1_out,
  output logic [N_PADS-1:0] af1_oe,
  output logic [N_PADS-1:0] af2_out,
  output logic [N_PADS-1:0] af2_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0][N_PADS-1:0] held;
  // peripherals change only on the clock, like registered function outputs
  always_ff @(posedge pclk) begin
    held <= stim;
  end
  // the mux wins where it drives; elsewhere the outside source sets the level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & held[0]);
  assign af1_out = held[1];
  assign af1_oe = held[2];
  assign af2_out = held[3];
  assign af2_oe = held[4];
endmodule : pad_far_side

//--- testbench/testbench.sv
// self-checking bench for the pad multiplexer, with a behavioural model of the pads
// assumes the pad_far_side model and a 10 MHz pclk
module testbench
  import pad_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, nmi_request, boot_rx;
  logic standby = 1'b0;
  logic boot_act = 1'b0;
  logic [N_PADS-1:0] pad_in, pad_out, pad_oe, pull_en, pull_up, slew, a1o, a1e, a2o, a2e, periph_in;
  logic [4:0][N_PADS-1:0] stim = '0;
  logic [N_SRC-1:0] src_in;
  logic [N_WAKE-1:0] wakeup_req, ext_irq;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int cfg [N_PADS];
  logic [15:0] gout [N_PORTS];
  logic [7:0] srcsel;
  int rst_pads [6] = '{0, 32, 33, 121, 122, 148};

  pad_alternate_function_mux u_pad_alternate_function_mux (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pull_en),
    .pad_pull_up(pull_up), .pad_slew_fast(slew), .af1_out(a1o), .af1_oe(a1e), .af2_out(a2o), .af2_oe(a2e),
    .periph_in(periph_in), .src_in(src_in), .nmi_request(nmi_request), .wakeup_req(wakeup_req),
    .ext_irq(ext_irq), .boot_rx(boot_rx), .standby_mode(standby), .boot_active(boot_act));
  pad_far_side u_pad_far_side (.pclk(pclk), .stim(stim), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in),
    .af1_out(a1o), .af1_oe(a1e), .af2_out(a2o), .af2_oe(a2e));

  always #50 pclk = ~pclk;

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // generous ceiling: the sequence needs a few hundred cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic cmp(input logic [N_PADS-1:0] g, input logic [N_PADS-1:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed latency: only the cycle ceiling ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp(N_PADS'(e), N_PADS'(1'b0));
    case (a[11:10])
      2'h0: cfg[a[9:2]] = d & 32'h00008F07;
      2'h1: gout[a[9:2]] = d[15:0];
      2'h3: srcsel = d[7:0];
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    cmp(N_PADS'(r), N_PADS'(x));
  endtask : rd

  task automatic reset_model;
    foreach (cfg[i]) cfg[i] = 0;
    foreach (gout[i]) gout[i] = 16'h0000;
    srcsel = 8'h00;
    cfg[32] = 32'h00000903;
    cfg[121] = 32'h00000903;
    cfg[122] = 32'h00000903;
    cfg[33] = 32'h00000A00;
  endtask : reset_model

  task automatic shake;
    logic [159:0] t;
    @(posedge pclk);
    for (int j = 0; j < 5; j++) begin
      t = {$urandom, $urandom, $urandom, $urandom, $urandom};
      stim[j] <= t[N_PADS-1:0];
    end
  endtask : shake

  task automatic check_all;
    logic [N_PADS-1:0] eo, ee, w, pin, nm, pe, pu, sf;
    logic [N_SRC-1:0] es;
    logic [N_WAKE-1:0] ew, ex;
    logic [1:0] sel;
    repeat (8) @(posedge pclk);
    for (int i = 0; i < N_PADS; i++) begin
      sel = cfg[i][11:10];
      nm[i] = cfg[i][15];
      pe[i] = cfg[i][1];
      pu[i] = cfg[i][0];
      sf[i] = cfg[i][2];
      eo[i] = sel == 2'h0 ? gout[i / 16][i % 16] : sel == 2'h1 ? stim[1][i] : stim[3][i];
      ee[i] = nm[i] ? 1'b0 : sel == 2'h0 ? cfg[i][9] : sel == 2'h1 ? stim[2][i] : stim[4][i];
      w[i] = ee[i] ? eo[i] : stim[0][i];
      pin[i] = w[i] & cfg[i][8];
    end
    for (int s = 0; s < N_SRC; s++) es[s] = pin[SRC_PAD[s][srcsel[2*s +: 2]]];
    for (int k = 0; k < N_WAKE; k++) begin
      ex[k] = pin[WAKE_PAD[k]];
      ew[k] = ex[k] & (~standby | WAKE_STANDBY_OK[k]);
    end
    cmp(pad_oe, ee);
    cmp(pad_out & ~nm, eo & ~nm);
    cmp(periph_in, pin);
    cmp(N_PADS'(src_in), N_PADS'(es));
    cmp(N_PADS'(ext_irq), N_PADS'(ex));
    cmp(N_PADS'(wakeup_req), N_PADS'(ew));
    cmp(N_PADS'(nmi_request), N_PADS'(|(pin & nm)));
    cmp(N_PADS'(boot_rx), N_PADS'(boot_act & pin[BOOT_PAD]));
    cmp(pull_en, pe);
    cmp(pull_up, pu);
    cmp(slew, sf);
  endtask : check_all

  initial begin
    logic [31:0] r;
    logic e;
    int idx;
    // falling edge at time zero so the async branch loads the pad setup before the first clock
    presetn <= 1'b0;
    void'($urandom(56));
    reset_model();
    check_all();
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_pads[i]) rd(12'(rst_pads[i] * 4), cfg[rst_pads[i]]);
    shake();
    check_all();
    wr(12'(TDO_PAD * 4), 32'h00000200);
    wr(12'h408, 32'h00000002);
    check_all();
    cmp(N_PADS'(pad_oe[TDO_PAD]), N_PADS'(1'b1));
    // every select code, random pads and field values
    for (int it = 0; it < 12; it++) begin
      // every third pad config write lands on the pad that the design's own assertions watch
      idx = (it % 3 == 0) ? 17 : $urandom_range(N_PADS - 1);
      wr(12'(idx * 4), ($urandom & 32'h00008307) | (32'(it % 4) << PCR_PA_LSB));
      wr(12'h400 + 12'(4 * $urandom_range(N_PORTS - 1)), $urandom & 32'h0000FFFF);
      shake();
      check_all();
    end
    wr(12'(50 * 4), 32'h00008500);
    shake();
    check_all();
    for (int s = 0; s < N_SRC; s++) for (int c = 0; c < N_CAND; c++) wr(12'(SRC_PAD[s][c] * 4), 32'h00000100);
    for (int it = 0; it < 4; it++) begin
      wr(12'hC00, $urandom & 32'h000000FF);
      shake();
      check_all();
    end
    for (int k = 0; k < N_WAKE; k++) wr(12'(WAKE_PAD[k] * 4), 32'h00000100);
    for (int m = 0; m < 4; m++) begin
      @(posedge pclk);
      standby <= m[0];
      boot_act <= m[1];
      shake();
      check_all();
    end
    apb(1'b0, 12'h320, 32'h00000000, r, e);
    cmp(N_PADS'({e, r}), N_PADS'(33'h100000000));
    wr(12'h808, 32'h0000FFFF);
    check_all();
    // second reset in mid-run restores the reset pad setup
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    reset_model();
    foreach (rst_pads[i]) rd(12'(rst_pads[i] * 4), cfg[rst_pads[i]]);
    check_all();
    tally_and_finish();
  end
endmodule : testbench
